// *** hw/rdd_pkg.sv ***
// Shared constants and types for the receive descriptor DMA control
package rdd_pkg;
   // Register byte offsets
   localparam logic [7:0] OFS_STATUS = 8'h0c;
   localparam logic [7:0] OFS_LIST = 8'h10;
   localparam logic [7:0] OFS_BURST = 8'h14;
   localparam logic [7:0] OFS_CTRL = 8'h18;
   localparam logic [7:0] OFS_URGENT = 8'h1c;
   // Reset values
   localparam logic [7:0] BURST_RST = 8'h08;
   localparam logic [7:0] URGENT_RST = 8'h04;
   // FIFO levels are kept in 32-byte units
   localparam int UNIT_SHIFT = 5;
   // Descriptor pointer alignment
   localparam logic [31:0] ALIGN_MASK = 32'hffff_fff8;
   // Descriptor word offsets
   localparam logic [31:0] DESC_NEXT = 32'h0000_0000;
   localparam logic [31:0] DESC_STAT = 32'h0000_0004;
   localparam logic [31:0] DESC_ADDR = 32'h0000_0008;
   localparam logic [31:0] DESC_LEN = 32'h0000_000c;
   // Byte count field and step per bus word
   localparam int LEN_W = 13;
   localparam logic [12:0] WORD_BYTES = 13'h0004;
   // Status bit positions
   localparam int ST_ERR = 14;
   localparam int ST_DONE = 15;
   localparam int ST_CAUSE_LO = 16;
   localparam int ST_CAUSE_HI = 20;
   localparam int ST_DRIBBLE = 23;
   localparam int ST_OVFL = 24;
   // Bits that exist; reserved bits stay zero
   localparam logic [31:0] STATUS_MASK = 32'h019f_dfff;
   // Control register bit
   localparam int CTRL_PAUSE = 0;
   // Host memory depth in words
   localparam int MEM_WORDS = 256;
   localparam int MEM_AW = 8;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_RD_NEXT = 3'b001,
      ST_RD_ADDR = 3'b010,
      ST_RD_LEN = 3'b011,
      ST_XFER = 3'b100,
      ST_DROP = 3'b101,
      ST_WB = 3'b110,
      ST_ADV = 3'b111
   } rdd_state_type;
endpackage

// *** hw/rdd_link_if.sv ***
// Bus master link between the DMA engine and host memory
`timescale 1ns/1ns
`default_nettype none
interface rdd_link_if;
   logic req;
   logic we;
   logic urgent;
   logic [31:0] addr;
   logic [31:0] wdata;
   logic ack;
   logic [31:0] rdata;

   modport dev (output req, output we, output urgent, output addr, output wdata, input ack, input rdata);
   modport mem (input req, input we, input urgent, input addr, input wdata, output ack, output rdata);
endinterface
`default_nettype wire

// *** hw/rdd_req_arb.sv ***
// Receive bus request decision from FIFO levels
`timescale 1ns/1ns
`default_nettype none
module rdd_req_arb
   import rdd_pkg::*;
(
   // FIFO levels, 32-byte units
   input wire logic [7:0] fifo_used,
   input wire logic [7:0] fifo_free,
   input wire logic frame_in_fifo,
   // Settings
   input wire logic [7:0] burst_level,
   input wire logic [7:0] urgent_level,
   input wire logic [12:0] frag_rem,
   input wire logic pause,
   // Decision
   output logic go,
   output logic urgent
);
   logic [12:0] used_bytes;

   // Saturate so a large level never wraps below the fragment length
   assign used_bytes = (fifo_used >= 8'h80) ? 13'h1fff : {fifo_used[7:0], 5'h00};
   assign urgent = !pause && (fifo_free < urgent_level); // RULE_23
   // A finished frame in the FIFO must drain even below the burst level
   assign go = !pause && (urgent // RULE_03 RULE_24
      || (fifo_used > burst_level) // RULE_01
      || (used_bytes > frag_rem) // RULE_02
      || frame_in_fifo);
endmodule
`default_nettype wire

// *** hw/rdd_dma_dev.sv ***
// Receive descriptor DMA engine with APB registers
//////////////////////////////////////////////////////////////////////
// What this block does
// [RULE_01] Request once FIFO use exceeds burst level
// [RULE_02] Request when use exceeds fragment length
// [RULE_03] Urgent request ignores burst level
// [RULE_04] Burst level 8 bits, resets to 8
// [RULE_05] Zero pointer means no descriptors; reset clears
// [RULE_06] Pointer is 8-byte aligned only
// [RULE_07] After descriptor, load pointer from next link
// [RULE_08] Zero next link idles until pointer written
// [RULE_09] Software pauses engine before pointer write
// [RULE_10] Status mirrors descriptor status word; reset clears
// [RULE_11] Software reads status while engine paused
// [RULE_12] Live byte count, cleared on fetch
// [RULE_13] Bit 14 summarises error causes
// [RULE_14] Bit 15 marks frame transfer done
// [RULE_15] Bit 16 FIFO drained too slowly
// [RULE_16] Bit 17 short frame under 60 bytes
// [RULE_17] Bit 18 alignment fault
// [RULE_18] Bit 19 check sequence fault
// [RULE_19] Bit 20 frame at or above size limit
// [RULE_20] Bit 23 extra trailing bits, informational
// [RULE_21] Out of buffer: discard rest, bit 24
// [RULE_22] Reserved status bits read zero
// [RULE_23] Urgent request when free space below level
// [RULE_24] Paused engine issues no new requests
//////////////////////////////////////////////////////////////////////
//
// Added by the designer: the APB slave port.
`timescale 1ns/1ns
`default_nettype none
module rdd_dma_dev
   import rdd_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst,
   // APB register port
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Receive FIFO side
   input wire logic [7:0] fifo_used,
   input wire logic [7:0] fifo_free,
   input wire logic frame_in_fifo,
   input wire logic rx_valid,
   input wire logic [31:0] rx_data,
   input wire logic rx_last,
   input wire logic [4:0] rx_cause,
   input wire logic rx_dribble,
   output logic rx_ready,
   // Engine state
   output logic engine_idle,
   // Host memory link
   rdd_link_if.dev bm
);
   rdd_state_type state_q;
   logic [31:0] ptr_q, status_q, prdata_q, addr_q, wdata_q, next_q, frag_addr_q;
   logic [7:0] burst_q, urgent_lvl_q;
   logic [12:0] frag_rem_q;
   logic [4:0] cause_q;
   logic pause_q, req_q, we_q, last_q, dribble_q;
   logic go, urgent, apb_wr, apb_hit, issue_wr, adv;

   //////////////////////////////////////////////////////////////////////
   // Request decision
   rdd_req_arb u_arb (
      .fifo_used(fifo_used),
      .fifo_free(fifo_free),
      .frame_in_fifo(frame_in_fifo),
      .burst_level(burst_q),
      .urgent_level(urgent_lvl_q),
      .frag_rem(frag_rem_q),
      .pause(pause_q),
      .go(go),
      .urgent(urgent)
   );

   //////////////////////////////////////////////////////////////////////
   // APB slave, zero wait states
   assign apb_hit = (paddr == OFS_STATUS) || (paddr == OFS_LIST) || (paddr == OFS_BURST)
      || (paddr == OFS_CTRL) || (paddr == OFS_URGENT);
   assign apb_wr = psel && penable && pwrite && apb_hit;
   assign pready = 1'b1;
   assign pslverr = psel && penable && !apb_hit;
   assign prdata = prdata_q;

   // Read data latched in the setup cycle
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         prdata_q <= 32'h0000_0000;
      end else if (psel && !penable && !pwrite) begin
         case (paddr)
            OFS_STATUS: prdata_q <= status_q & STATUS_MASK; // RULE_22
            OFS_LIST: prdata_q <= ptr_q;
            OFS_BURST: prdata_q <= {24'h00_0000, burst_q};
            OFS_CTRL: prdata_q <= {31'h0000_0000, pause_q};
            OFS_URGENT: prdata_q <= {24'h00_0000, urgent_lvl_q};
            default: prdata_q <= 32'h0000_0000;
         endcase
      end
   end

   // Settings registers
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         burst_q <= BURST_RST; // RULE_04
         urgent_lvl_q <= URGENT_RST; // RULE_23
         pause_q <= 1'b0;
      end else if (apb_wr) begin
         if (paddr == OFS_BURST) begin
            burst_q <= pwdata[7:0]; // RULE_04
         end
         if (paddr == OFS_URGENT) begin
            urgent_lvl_q <= pwdata[7:0];
         end
         if (paddr == OFS_CTRL) begin
            pause_q <= pwdata[CTRL_PAUSE];
         end
      end
   end

   //////////////////////////////////////////////////////////////////////
   // Descriptor pointer
   assign adv = (state_q == ST_ADV);

   // Software write wins over the next-link load when both fall in one cycle
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         ptr_q <= 32'h0000_0000; // RULE_05
      end else if (apb_wr && paddr == OFS_LIST) begin
         ptr_q <= pwdata & ALIGN_MASK; // RULE_06 RULE_09
      end else if (adv) begin
         ptr_q <= next_q & ALIGN_MASK; // RULE_07
      end
   end

   //////////////////////////////////////////////////////////////////////
   // Engine and bus master link
   assign issue_wr = (state_q == ST_XFER) && !req_q && rx_valid && go && (frag_rem_q != 13'h0000);
   assign rx_ready = issue_wr || (state_q == ST_DROP && rx_valid)
      || (state_q == ST_XFER && !req_q && !pause_q && rx_valid && frag_rem_q == 13'h0000);
   assign engine_idle = (state_q == ST_IDLE);
   assign bm.req = req_q;
   assign bm.we = we_q;
   assign bm.addr = addr_q;
   assign bm.wdata = wdata_q;
   assign bm.urgent = urgent && (state_q == ST_XFER);

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         state_q <= ST_IDLE;
         status_q <= 32'h0000_0000; // RULE_10
         req_q <= 1'b0;
         we_q <= 1'b0;
         addr_q <= 32'h0000_0000;
         wdata_q <= 32'h0000_0000;
         next_q <= 32'h0000_0000;
         frag_addr_q <= 32'h0000_0000;
         frag_rem_q <= 13'h0000;
         last_q <= 1'b0;
         cause_q <= 5'h00;
         dribble_q <= 1'b0;
      end else begin
         case (state_q)
            ST_IDLE: begin
               // Zero pointer: nothing to fill
               if (ptr_q != 32'h0000_0000 && !pause_q) begin // RULE_05 RULE_08 RULE_24
                  status_q <= 32'h0000_0000; // RULE_12
                  state_q <= ST_RD_NEXT;
               end
            end
            ST_RD_NEXT, ST_RD_ADDR, ST_RD_LEN: begin
               if (req_q) begin
                  if (bm.ack) begin
                     req_q <= 1'b0;
                     if (state_q == ST_RD_NEXT) begin
                        next_q <= bm.rdata;
                        state_q <= ST_RD_ADDR;
                     end else if (state_q == ST_RD_ADDR) begin
                        frag_addr_q <= bm.rdata;
                        state_q <= ST_RD_LEN;
                     end else begin
                        frag_rem_q <= bm.rdata[LEN_W-1:0];
                        state_q <= ST_XFER;
                     end
                  end
               end else if (!pause_q) begin // RULE_24
                  req_q <= 1'b1;
                  we_q <= 1'b0;
                  if (state_q == ST_RD_NEXT) begin
                     addr_q <= ptr_q + DESC_NEXT;
                  end else if (state_q == ST_RD_ADDR) begin
                     addr_q <= ptr_q + DESC_ADDR;
                  end else begin
                     addr_q <= ptr_q + DESC_LEN;
                  end
               end
            end
            ST_XFER: begin
               if (req_q) begin
                  if (bm.ack) begin
                     req_q <= 1'b0;
                     // One word per step, 4 bytes off the remaining buffer length
                     status_q[LEN_W-1:0] <= status_q[LEN_W-1:0] + WORD_BYTES; // RULE_12
                     frag_rem_q <= frag_rem_q - WORD_BYTES;
                     frag_addr_q <= frag_addr_q + 32'h0000_0004;
                     if (last_q) begin
                        state_q <= ST_WB;
                     end
                  end
               end else if (issue_wr) begin
                  req_q <= 1'b1;
                  we_q <= 1'b1;
                  addr_q <= frag_addr_q;
                  wdata_q <= rx_data;
                  last_q <= rx_last;
                  cause_q <= rx_cause;
                  dribble_q <= rx_dribble;
               end else if (rx_valid && !pause_q && frag_rem_q == 13'h0000) begin // RULE_24
                  status_q[ST_OVFL] <= 1'b1; // RULE_21
                  cause_q <= rx_cause;
                  dribble_q <= rx_dribble;
                  state_q <= rx_last ? ST_WB : ST_DROP;
               end
            end
            ST_DROP: begin
               // Remainder of the frame is thrown away
               if (rx_valid && rx_last) begin // RULE_21
                  cause_q <= rx_cause;
                  dribble_q <= rx_dribble;
                  state_q <= ST_WB;
               end
            end
            ST_WB: begin
               if (req_q) begin
                  if (bm.ack) begin
                     req_q <= 1'b0;
                     state_q <= ST_ADV;
                  end
               end else if (!pause_q) begin // RULE_24
                  // Causes: overrun, short, alignment, check sequence, too long
                  status_q[ST_CAUSE_HI:ST_CAUSE_LO] <= cause_q; // RULE_15 RULE_16 RULE_17 RULE_18 RULE_19
                  status_q[ST_ERR] <= |cause_q; // RULE_13
                  status_q[ST_DRIBBLE] <= dribble_q; // RULE_20
                  status_q[ST_DONE] <= 1'b1; // RULE_14
                  req_q <= 1'b1;
                  we_q <= 1'b1;
                  addr_q <= ptr_q + DESC_STAT;
                  wdata_q <= {status_q[31:ST_DRIBBLE+1], dribble_q, status_q[ST_DRIBBLE-1:ST_CAUSE_HI+1],
                     cause_q, 1'b1, |cause_q, status_q[ST_ERR-1:0]} & STATUS_MASK; // RULE_10 RULE_22
               end
            end
            ST_ADV: begin
               // Done bit stays visible until the next fetch clears it
               state_q <= ST_IDLE; // RULE_07 RULE_08
            end
            default: begin
               state_q <= ST_IDLE;
            end
         endcase
      end
   end
endmodule
`default_nettype wire

// *** hw/rdd_mem_host.sv ***
// Host memory end of the bus master link
`timescale 1ns/1ns
`default_nettype none
module rdd_mem_host
   import rdd_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst,
   // Software access port, served when the link is quiet
   input wire logic sw_req,
   input wire logic sw_we,
   input wire logic [31:0] sw_addr,
   input wire logic [31:0] sw_wdata,
   output logic sw_ack,
   output logic [31:0] sw_rdata,
   // Link to the DMA engine
   rdd_link_if.mem bm
);
   logic [31:0] mem_q [MEM_WORDS];
   logic ack_q;
   logic sw_ack_q;
   logic [31:0] rdata_q;
   logic [31:0] sw_rdata_q;
   logic link_take;
   logic sw_take;

   // Link has priority; the engine cannot be stalled by software
   assign link_take = bm.req && !ack_q;
   assign sw_take = sw_req && !sw_ack_q && !bm.req;
   assign bm.ack = ack_q;
   assign bm.rdata = rdata_q;
   assign sw_ack = sw_ack_q;
   assign sw_rdata = sw_rdata_q;

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         ack_q <= 1'b0;
         sw_ack_q <= 1'b0;
      end else begin
         ack_q <= link_take;
         sw_ack_q <= sw_take;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         rdata_q <= 32'h0000_0000;
         sw_rdata_q <= 32'h0000_0000;
      end else begin
         if (link_take) begin
            rdata_q <= mem_q[bm.addr[MEM_AW+1:2]];
         end
         if (sw_take) begin
            sw_rdata_q <= mem_q[sw_addr[MEM_AW+1:2]];
         end
      end
   end

   // Memory contents are not reset
   always_ff @(posedge clk_sys) begin
      if (link_take && bm.we) begin
         mem_q[bm.addr[MEM_AW+1:2]] <= bm.wdata;
      end else if (sw_take && sw_we) begin
         mem_q[sw_addr[MEM_AW+1:2]] <= sw_wdata;
      end
   end
endmodule
`default_nettype wire

// *** dv/rdd_link_properties.sv ***
// Link protocol and status write-back checks for the receive DMA pair
`timescale 1ns/1ns
`default_nettype none
module rdd_link_properties
   import rdd_pkg::*;
#(
   parameter logic [31:0] DESC_LIMIT = 32'h0000_0100
)
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // Link
   input wire logic req,
   input wire logic we,
   input wire logic urgent,
   input wire logic [31:0] addr,
   input wire logic [31:0] wdata,
   input wire logic ack,
   input wire logic [31:0] rdata
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (rst);
   logic [12:0] cnt_q;
   logic dsc;
   logic wb;
   // Descriptors live below the limit, buffers above
   assign dsc = addr < DESC_LIMIT;
   assign wb = req && we && dsc;
   always_ff @(posedge clk_sys) begin
      if (rst || (ack && !we)) begin
         cnt_q <= '0;
      end else if (ack && we && !dsc) begin
         cnt_q <= cnt_q + WORD_BYTES;
      end
   end
   property p_ack_exact; req && !ack |=> ack; endproperty
   a_ack_exact: assert property (p_ack_exact) else $error("ack late");
   property p_req_drop; ack |=> !req && !ack; endproperty
   a_req_drop: assert property (p_req_drop) else $error("req kept after ack");
   property p_hold; req && !ack |=> $stable(addr) && $stable(we) && $stable(wdata); endproperty
   a_hold: assert property (p_hold) else $error("request changed while waiting");
   property p_no_stray; ack |-> $past(req); endproperty
   a_no_stray: assert property (p_no_stray) else $error("ack without request");
   property p_rd_place; req && !we |-> dsc && addr[1:0] == 2'b00; endproperty
   a_rd_place: assert property (p_rd_place) else $error("read outside descriptors");
   property p_wb_form; wb |-> addr[2:0] == 3'h4 && wdata[ST_DONE] && (wdata & ~STATUS_MASK) == 32'h0; endproperty
   a_wb_form: assert property (p_wb_form) else $error("bad status write-back");
   property p_err_sum; wb |-> wdata[ST_ERR] == (|wdata[ST_CAUSE_HI:ST_CAUSE_LO]); endproperty
   a_err_sum: assert property (p_err_sum) else $error("error summary wrong");
   property p_count; wb && !wdata[ST_OVFL] |-> wdata[12:0] == cnt_q; endproperty
   a_count: assert property (p_count) else $error("byte count wrong");
   property p_urgent; req && urgent |-> we && !dsc; endproperty
   a_urgent: assert property (p_urgent) else $error("urgent outside data");
endmodule
`default_nettype wire

// *** dv/rdd_tb_top.sv ***
// Self-checking bench for the receive DMA engine and host memory
`timescale 1ns/1ns
`default_nettype none
module rdd_tb_top;
   import rdd_pkg::*;
   typedef struct packed {
      logic wr;
      logic [7:0] a;
      logic [31:0] d;
      logic [31:0] x;
      logic e;
   } rdd_row_type;
   localparam rdd_row_type ROWS [10] = '{
      '{1'b0, OFS_STATUS, 32'h0, 32'h0, 1'b0}, '{1'b0, OFS_LIST, 32'h0, 32'h0, 1'b0},
      '{1'b0, OFS_BURST, 32'h0, 32'h8, 1'b0}, '{1'b0, OFS_URGENT, 32'h0, 32'h4, 1'b0},
      '{1'b1, OFS_CTRL, 32'h1, 32'h1, 1'b0}, '{1'b1, OFS_LIST, 32'h13, 32'h10, 1'b0},
      '{1'b1, OFS_LIST, 32'h0, 32'h0, 1'b0}, '{1'b1, OFS_STATUS, 32'hffff, 32'h0, 1'b0},
      '{1'b1, OFS_BURST, 32'h1ff, 32'hff, 1'b0}, '{1'b0, 8'h20, 32'h0, 32'h0, 1'b1}};
   logic clk_sys, rst, psel, penable, pwrite, pready, pslverr;
   logic [7:0] paddr, fifo_used, fifo_free;
   logic [31:0] pwdata, prdata, rx_data, sw_addr, sw_wdata, sw_rdata, rd, ex;
   logic frame_in_fifo, rx_valid, rx_last, rx_dribble, rx_ready, engine_idle, sw_req, sw_we, sw_ack, err;
   logic [4:0] rx_cause;
   logic [38:0] strm [16];
   int n_fail, n_compared, n_words, i, base, w0;
   int n_wr = 0, n_req = 0, idx = 0;
   rdd_link_if lk();
   rdd_dma_dev i_rdd_dma_dev(.clk_sys, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .fifo_used, .fifo_free, .frame_in_fifo, .rx_valid, .rx_data, .rx_last, .rx_cause, .rx_dribble,
      .rx_ready, .engine_idle, .bm(lk.dev));
   rdd_mem_host i_rdd_mem_host(.clk_sys, .rst, .sw_req, .sw_we, .sw_addr, .sw_wdata, .sw_ack, .sw_rdata,
      .bm(lk.mem));
   rdd_link_properties i_rdd_link_properties(.clk_sys(clk_sys), .rst(rst), .req(lk.req), .we(lk.we),
      .urgent(lk.urgent), .addr(lk.addr), .wdata(lk.wdata), .ack(lk.ack), .rdata(lk.rdata));
   // Receive FIFO model: word stream popped on handshake
   assign rx_valid = idx < n_words;
   assign {rx_last, rx_dribble, rx_cause, rx_data} = strm[idx[3:0]];
   always @(posedge clk_sys) begin
      if (rx_valid && rx_ready) begin
         idx <= idx + 1;
      end
      if (lk.ack && lk.we && lk.addr >= 32'h100) begin
         n_wr <= n_wr + 1;
      end
      if (lk.req) begin
         n_req <= n_req + 1;
      end
   end
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   task automatic complete_run;
      $display("Compared %0d, mismatches %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
      n_compared++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] %0t %s: got %h expected %h", $time, what, got, exp);
      end
   endtask
   task automatic hang(input logic ok);
      if (!ok) begin
         check(32'h0, 32'h1, "wait bound used up");
         complete_run();
      end
   endtask
   // APB master: setup, then access until pready
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int k;
      @(posedge clk_sys);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge clk_sys);
         k++;
      end while (pready !== 1'b1 && k < 20);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      hang(pready === 1'b1);
   endtask
   task automatic mem(input logic wr, input int a, input logic [31:0] d);
      int k;
      @(posedge clk_sys);
      sw_req <= 1'b1;
      sw_we <= wr;
      sw_addr <= a;
      sw_wdata <= d;
      k = 0;
      do begin
         @(posedge clk_sys);
         k++;
      end while (sw_ack !== 1'b1 && k < 200);
      rd = sw_rdata;
      sw_req <= 1'b0;
      hang(sw_ack === 1'b1);
   endtask
   task automatic wait_idle(input int need);
      int k;
      k = 0;
      do begin
         @(posedge clk_sys);
         k++;
      end while (!(idx == need && engine_idle === 1'b1) && k < 3000);
      hang(k < 3000);
   endtask
   initial begin
      {psel, penable, pwrite, paddr, pwdata, sw_req, sw_we, sw_addr, sw_wdata} = '0;
      {fifo_used, fifo_free, frame_in_fifo, n_fail, n_compared, n_words} = '0;
      foreach (strm[j]) strm[j] = '0;
      rst = 1'b1;
      repeat (16) @(posedge clk_sys);
      rst <= 1'b0;
      foreach (ROWS[r]) begin
         if (ROWS[r].wr) apb(1'b1, ROWS[r].a, ROWS[r].d);
         apb(1'b0, ROWS[r].a, 32'h0);
         check(rd, ROWS[r].x, "register read");
         check({31'h0, err}, {31'h0, ROWS[r].e}, "slave error");
      end
      $display("Test register table done");
      // Six chained descriptors, one error cause each for the first five, the last too small
      for (int k = 0; k < 6; k++) begin
         base = 32'h40 + 16 * k;
         mem(1'b1, base, (k < 5) ? base + 16 : 0);
         mem(1'b1, base + 4, 32'h0);
         mem(1'b1, base + 8, 32'h100 + 16 * k);
         mem(1'b1, base + 12, (k < 5) ? 32'h8 : 32'h4);
         strm[2 * k] = {7'h0, 32'ha000_0000 + 2 * k};
         strm[2 * k + 1] = {1'b1, k % 2 == 1 && k < 5, (k < 5) ? 5'h1 << k : 5'h0, 32'ha000_0001 + 2 * k};
      end
      mem(1'b1, 32'h154, 32'h0);
      apb(1'b1, OFS_BURST, 32'h8);
      fifo_used <= 8'h1;
      fifo_free <= 8'h40;
      n_words <= 12;
      apb(1'b1, OFS_LIST, 32'h40);
      w0 = n_req;
      repeat (40) @(posedge clk_sys);
      check(n_req - w0, 32'h0, "request while paused");
      apb(1'b1, OFS_CTRL, 32'h0);
      wait_idle(12);
      for (int k = 0; k < 6; k++) begin
         ex = (k < 5) ? 32'h0000_c008 | (32'h1 << (16 + k)) | ((k % 2) ? 32'h0080_0000 : 32'h0) : 32'h0100_8004;
         mem(1'b0, 32'h44 + 16 * k, 32'h0);
         check(rd, ex, "status word");
         mem(1'b0, 32'h100 + 16 * k, 32'h0);
         check(rd, 32'ha000_0000 + 2 * k, "buffer word");
      end
      mem(1'b0, 32'h154, 32'h0);
      check(rd, 32'h0, "dropped word written");
      apb(1'b0, OFS_LIST, 32'h0);
      check(rd, 32'h0, "pointer after last link");
      apb(1'b1, OFS_CTRL, 32'h1);
      apb(1'b0, OFS_STATUS, 32'h0);
      check(rd, 32'h0100_8004, "status register");
      $display("Test descriptor chain done");
      // Used space equal to burst level must not start data
      mem(1'b1, 32'ha0, 32'h0);
      mem(1'b1, 32'ha8, 32'h300);
      mem(1'b1, 32'hac, 32'h1000);
      for (int k = 12; k < 15; k++) strm[k] = {k == 14, 6'h0, 32'hb000_0000 + k};
      fifo_used <= 8'h8;
      n_words <= 15;
      apb(1'b1, OFS_LIST, 32'ha0);
      apb(1'b1, OFS_CTRL, 32'h0);
      w0 = n_wr;
      repeat (60) @(posedge clk_sys);
      check(n_wr - w0, 32'h0, "data below burst level");
      fifo_free <= 8'h3;
      i = 0;
      do begin
         @(posedge clk_sys);
         i++;
      end while (!(lk.req === 1'b1 && lk.we === 1'b1 && lk.addr >= 32'h100) && i < 200);
      hang(i < 200);
      check({31'h0, lk.urgent}, 32'h1, "urgent flag");
      fifo_free <= 8'h40;
      fifo_used <= 8'h9;
      wait_idle(15);
      mem(1'b0, 32'ha4, 32'h0);
      check(rd, 32'h0000_800c, "status after gating");
      $display("Test request gating done");
      // Move settings off their reset values so the reset checks can trip
      apb(1'b1, OFS_BURST, 32'h20);
      apb(1'b1, OFS_CTRL, 32'h1);
      rst <= 1'b1;
      repeat (2) @(posedge clk_sys);
      rst <= 1'b0;
      apb(1'b0, OFS_STATUS, 32'h0);
      check(rd, 32'h0, "status after reset");
      apb(1'b0, OFS_BURST, 32'h0);
      check(rd, 32'h8, "burst after reset");
      apb(1'b0, OFS_CTRL, 32'h0);
      check(rd, 32'h0, "pause after reset");
      $display("Test second reset done");
      complete_run();
   end
endmodule
`default_nettype wire
